// file: cmpc_pkg.sv
package cmpc_pkg;
   // --------------------------------------------------------------
   // Register map (byte addresses on the AHB-Lite bus).
   // --------------------------------------------------------------
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CLEAR = 12'h008;
   localparam logic [11:0] ADDR_ENABLE = 12'h00C;
   localparam logic [11:0] ADDR_PORT = 12'h010;

   // --------------------------------------------------------------
   // Control register fields.
   // --------------------------------------------------------------
   localparam int unsigned BIT_INPUT_SEL = 7;
   localparam int unsigned BIT_POWER_ON = 6;
   localparam int unsigned BIT_INVERT = 5;
   localparam int unsigned BIT_RESULT = 4;
   localparam int unsigned BIT_PATH = 3;
   localparam int unsigned BIT_EDGE_HI = 2;
   localparam int unsigned BIT_EDGE_LO = 1;
   localparam int unsigned BIT_HYST = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h81;
   localparam logic [7:0] CONTROL_WMASK = 8'hEF;

   // --------------------------------------------------------------
   // Status, enable and clear layout.
   // --------------------------------------------------------------
   localparam int unsigned STAT_EDGE = 0;
   localparam int unsigned STAT_WAKE = 1;
   localparam int unsigned STAT_W = 2;

   // --------------------------------------------------------------
   // Port word layout: direction in bits 1:0, data in bits 9:8.
   // --------------------------------------------------------------
   localparam int unsigned PORT_DIR_LSB = 0;
   localparam int unsigned PORT_DATA_LSB = 8;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      CMPC_EDGE_RISE,
      CMPC_EDGE_FALL,
      CMPC_EDGE_BOTH
   } cmpc_edge_type;
endpackage

// file: cmpc_edge.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// Synchroniser, polarity and edge detector for the result bit.
// --------------------------------------------------------------
module cmpc_edge (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic raw_in,
   input wire logic invert,
   input wire logic [1:0] edge_sel,
   output logic result_bit,
   output logic edge_hit
);

   logic sync1_q;
   logic sync2_q;
   logic result_q;
   logic result_d;
   logic armed_q;
   logic rise;
   logic fall;

   // Two flops before anything reads the analog output.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // Polarity applied after synchronising, so edges stay single.
   assign result_d = sync2_q ^ invert;

   // The armed flag stops a spurious edge on the first cycle after reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         result_q <= result_d;
         armed_q <= 1'b1;
      end
   end

   assign result_bit = result_q;

   // The result bit must be the synchronised level with polarity applied, one cycle on.
   chk_result_pol: assert property (@(posedge hclk) disable iff (!hresetn)
      result_q == ($past(sync2_q) ^ $past(invert))) else $error("result polarity wrong");
   chk_sync_chain: assert property (@(posedge hclk) disable iff (!hresetn)
      sync2_q == $past(sync1_q)) else $error("synchroniser skipped");
   assign rise = armed_q && !result_q && result_d;
   assign fall = armed_q && result_q && !result_d;

   // Edge selection: 00 rising, 01 falling, 1x both.
   always_comb begin
      if (edge_sel[1]) begin
         edge_hit = rise | fall;
      end else if (edge_sel[0]) begin
         edge_hit = fall;
      end else begin
         edge_hit = rise;
      end
   end

endmodule

`default_nettype wire

// file: cmpc_top.sv
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cmpc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic comparator_raw,
   input wire logic core_sleeping,
   input wire logic [1:0] pull_high_cfg,
   output logic [1:0] pull_high_en,
   output logic [1:0] io_function_en,
   output logic comparator_power_on,
   output logic hysteresis_enable,
   output logic result_output_pin,
   output logic result_output_pin_oe,
   output logic irq,
   output logic wake_request
);

   // --------------------------------------------------------------
   // Registers.
   // --------------------------------------------------------------
   logic [7:0] control_q;
   logic [cmpc_pkg::STAT_W-1:0] status_q;
   logic [cmpc_pkg::STAT_W-1:0] enable_q;
   logic [1:0] port_dir_q;
   logic [1:0] port_data_q;
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic result_bit;
   logic edge_hit;
   logic sleep_s1_q;
   logic sleep_s2_q;
   logic set_event;
   logic set_wake;
   logic [cmpc_pkg::STAT_W-1:0] clr_bits;
   logic [7:0] control_view;

   wire input_pin_select = control_q[cmpc_pkg::BIT_INPUT_SEL];
   wire output_invert = control_q[cmpc_pkg::BIT_INVERT];
   wire out_path_internal = control_q[cmpc_pkg::BIT_PATH];
   wire [1:0] interrupt_edge_select = control_q[cmpc_pkg::BIT_EDGE_HI:cmpc_pkg::BIT_EDGE_LO];

   // --------------------------------------------------------------
   // Bus slave: zero wait states, writes land in the data phase.
   // --------------------------------------------------------------
   function automatic logic is_word_access(input logic [1:0] tr, input logic [2:0] sz);
      is_word_access = (tr == cmpc_pkg::HTRANS_NONSEQ) && (sz == cmpc_pkg::HSIZE_WORD);
   endfunction

   wire take = hsel && hready && is_word_access(htrans, hsize);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= take && hwrite;
         wr_addr_q <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire wr_ctrl = wr_pend_q && (wr_addr_q == cmpc_pkg::ADDR_CONTROL);
   wire wr_clr = wr_pend_q && (wr_addr_q == cmpc_pkg::ADDR_CLEAR);
   wire wr_en = wr_pend_q && (wr_addr_q == cmpc_pkg::ADDR_ENABLE);
   wire wr_port = wr_pend_q && (wr_addr_q == cmpc_pkg::ADDR_PORT);

   // Control register; the result bit is read only and not stored here.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_q <= cmpc_pkg::CONTROL_RESET;
      end else if (wr_ctrl) begin
         control_q <= hwdata[7:0] & cmpc_pkg::CONTROL_WMASK;
      end
   end

   // Port direction and data for the two shared input pins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_dir_q <= 2'h3;
         port_data_q <= 2'h0;
      end else if (wr_port) begin
         port_dir_q <= hwdata[cmpc_pkg::PORT_DIR_LSB +: 2];
         port_data_q <= hwdata[cmpc_pkg::PORT_DATA_LSB +: 2];
      end
   end

   // Interrupt enable register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_q <= '0;
      end else if (wr_en) begin
         enable_q <= hwdata[cmpc_pkg::STAT_W-1:0];
      end
   end

   // --------------------------------------------------------------
   // Result path and edge detection.
   // --------------------------------------------------------------
   cmpc_edge u_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw_in(comparator_raw),
      .invert(output_invert),
      .edge_sel(interrupt_edge_select),
      .result_bit(result_bit),
      .edge_hit(edge_hit)
   );

   // Sleep state comes from the power manager, treated as asynchronous.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         sleep_s1_q <= core_sleeping;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   // A powered-off comparator yields no events; edges come only from the result bit.
   assign set_event = edge_hit && comparator_power_on;
   // Wake only when the flag rises now; a flag already set blocks it.
   assign set_wake = set_event && sleep_s2_q && !status_q[cmpc_pkg::STAT_EDGE];
   assign clr_bits = wr_clr ? hwdata[cmpc_pkg::STAT_W-1:0] : '0;

   // Sticky status: a set in the same cycle as a clear wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= '0;
      end else begin
         status_q[cmpc_pkg::STAT_EDGE] <= set_event
            | (status_q[cmpc_pkg::STAT_EDGE] & ~clr_bits[cmpc_pkg::STAT_EDGE]);
         status_q[cmpc_pkg::STAT_WAKE] <= set_wake
            | (status_q[cmpc_pkg::STAT_WAKE] & ~clr_bits[cmpc_pkg::STAT_WAKE]);
      end
   end

   // Level interrupt while any enabled status bit stands.
   assign irq = |(status_q & enable_q);
   assign wake_request = status_q[cmpc_pkg::STAT_WAKE];

   // --------------------------------------------------------------
   // Analog and pin controls; sleep does not touch any of these.
   // --------------------------------------------------------------
   assign comparator_power_on = control_q[cmpc_pkg::BIT_POWER_ON];
   assign hysteresis_enable = control_q[cmpc_pkg::BIT_HYST];
   assign io_function_en = {2{~input_pin_select}};
   assign pull_high_en = input_pin_select ? 2'h0 : pull_high_cfg;
   assign result_output_pin = result_bit;
   assign result_output_pin_oe = !out_path_internal;

   // --------------------------------------------------------------
   // Read mux.
   // --------------------------------------------------------------
   always_comb begin
      control_view = control_q;
      control_view[cmpc_pkg::BIT_RESULT] = result_bit;
   end

   // Read data is registered in the data phase cycle that follows the address.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         if (haddr == cmpc_pkg::ADDR_CONTROL) begin
            hrdata <= {24'h000000, control_view};
         end else if (haddr == cmpc_pkg::ADDR_STATUS) begin
            hrdata <= {30'h0, status_q};
         end else if (haddr == cmpc_pkg::ADDR_ENABLE) begin
            hrdata <= {30'h0, enable_q};
         end else if (haddr == cmpc_pkg::ADDR_PORT) begin
            // Comparator pins read zero as inputs, else port data.
            hrdata <= input_pin_select ? {30'h0, port_data_q & ~port_dir_q}
                                       : {22'h0, port_data_q, 6'h00, port_dir_q};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // --------------------------------------------------------------
   // Assertions.
   // --------------------------------------------------------------
   chk_pullup_cut: assert property (@(posedge hclk) disable iff (!hresetn)
      input_pin_select |-> pull_high_en == 2'h0) else $error("pull-high left on comparator pins");
   chk_io_release: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && hwdata[cmpc_pkg::BIT_INPUT_SEL]) |=> io_function_en == 2'h0)
      else $error("io function wrong");
   chk_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      set_event |=> status_q[cmpc_pkg::STAT_EDGE]) else $error("flag not set");
   chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      (status_q[0] && enable_q[0]) |-> irq) else $error("irq missing");
   chk_wake_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wake_request) |-> $past(sleep_s2_q) && $past(comparator_power_on)) else $error("bad wake");
   chk_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
      (interrupt_edge_select == 2'h0 && edge_hit) |-> !result_bit ##1 result_bit)
      else $error("edge type wrong");
   chk_pin_path: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && hwdata[cmpc_pkg::BIT_PATH]) |=> !result_output_pin_oe) else $error("pin path wrong");
   chk_no_event_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !comparator_power_on |=> !$rose(status_q[cmpc_pkg::STAT_EDGE]))
      else $error("event while off");
   chk_sleep_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
      (!wr_ctrl && $rose(sleep_s2_q)) |=> $stable(control_q)) else $error("sleep changed control");

   // Register writes must reach the analog controls one cycle after the data phase.
   chk_hyst_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> hysteresis_enable == $past(hwdata[cmpc_pkg::BIT_HYST])) else $error("hysteresis not written");
   chk_power_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> comparator_power_on == $past(hwdata[cmpc_pkg::BIT_POWER_ON])) else $error("power not written");

   // Read data is checked against the state seen in the address phase.
   chk_read_result: assert property (@(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr == cmpc_pkg::ADDR_CONTROL) |=> hrdata[cmpc_pkg::BIT_RESULT] == $past(result_bit))
      else $error("result bit read wrong");
   chk_port_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr == cmpc_pkg::ADDR_PORT && input_pin_select)
      |=> hrdata[1:0] == ($past(port_data_q) & ~$past(port_dir_q)))
      else $error("port read wrong");

   cov_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
   cov_wake: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wake_request));
   cov_clear: cover property (@(posedge hclk) disable iff (!hresetn) wr_clr && status_q[0]);
   cov_both: cover property (@(posedge hclk) disable iff (!hresetn) interrupt_edge_select[1] && edge_hit);

endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_fail++; $display("BAD %s exp %h got %h", nm, ex, gt); end end

module tb;
   // ----------------------------------------------------------
   // Stimulus and observed signals.
   // ----------------------------------------------------------
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h00000000;
   logic comparator_raw = 1'b0;
   logic core_sleeping = 1'b0;
   logic [1:0] pull_high_cfg = 2'h0;
   wire logic hready;
   wire logic [31:0] hrdata;
   wire logic hresp;
   wire logic [1:0] pull_high_en;
   wire logic [1:0] io_function_en;
   wire logic comparator_power_on;
   wire logic hysteresis_enable;
   wire logic result_output_pin;
   wire logic result_output_pin_oe;
   wire logic irq;
   wire logic wake_request;
   int n_fail = 0;
   int n_tests = 0;
   int seed = 32'h69a05b32;
   logic [31:0] d;
   logic [7:0] c;
   logic [1:0] h;

   // The clock toggles every half period of 25 ns.
   always #25 hclk = ~hclk;

   cmpc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .comparator_raw(comparator_raw), .core_sleeping(core_sleeping),
      .pull_high_cfg(pull_high_cfg), .pull_high_en(pull_high_en), .io_function_en(io_function_en),
      .comparator_power_on(comparator_power_on), .hysteresis_enable(hysteresis_enable),
      .result_output_pin(result_output_pin), .result_output_pin_oe(result_output_pin_oe),
      .irq(irq), .wake_request(wake_request));

   // ----------------------------------------------------------
   // Bus tasks and expectation functions.
   // ----------------------------------------------------------
   // One single word transfer; waits on the bus ready with a bound.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= cmpc_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= cmpc_pkg::HSIZE_WORD;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         n_fail++;
      end
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, a, wd, x);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] x);
      bus(1'b0, a, 32'h00000000, x);
   endtask

   // Waits out the synchroniser and edge pipeline, then steps off the edge.
   task automatic settle(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask

   // Whether a change of the result bit from o to n qualifies for the edge mode s.
   function automatic logic hit(input logic [1:0] s, input logic o, input logic n);
      hit = s[1] ? (o != n) : (s[0] ? (o & ~n) : (~o & n));
   endfunction

   task automatic wrap_up;
      if ((n_fail == 0) && (n_tests > 0)) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A hang is cut short long after the sequence should have ended.
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      wrap_up();
   end

   // ----------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      settle(2);
      `CHK("io_fn_rst", 2'b00, io_function_en)
      `CHK("pull_rst", 2'b00, pull_high_en)
      `CHK("power_rst", 1'b0, comparator_power_on)
      `CHK("hyst_rst", 1'b1, hysteresis_enable)
      `CHK("oe_rst", 1'b1, result_output_pin_oe)
      `CHK("hresp", 1'b0, hresp)
      `CHK("hready", 1'b1, hready)
      rd(cmpc_pkg::ADDR_CONTROL, d);
      `CHK("ctrl_rst", {24'h000000, cmpc_pkg::CONTROL_RESET}, d)
      rd(cmpc_pkg::ADDR_PORT, d);
      `CHK("port_rst", 2'b00, d[1:0])
      // Random control words, pin requests and comparator levels.
      for (int i = 0; i < 24; i++) begin
         c = $random(seed);
         h = $random(seed);
         pull_high_cfg <= h;
         comparator_raw <= $random(seed);
         wr(cmpc_pkg::ADDR_CONTROL, {24'h000000, c});
         settle(6);
         `CHK("io_fn", {2{~c[7]}}, io_function_en)
         `CHK("pull_en", c[7] ? 2'b00 : h, pull_high_en)
         `CHK("power", c[6], comparator_power_on)
         `CHK("hyst", c[0], hysteresis_enable)
         `CHK("oe", ~c[3], result_output_pin_oe)
         `CHK("pin", comparator_raw ^ c[5], result_output_pin)
         rd(cmpc_pkg::ADDR_CONTROL, d);
         `CHK("ctrl", {24'h000000, c[7:5], comparator_raw ^ c[5], c[3:0]}, d)
      end
      // Every edge mode with both polarities; the enable follows the polarity to cover masking.
      for (int s = 0; s < 4; s++) begin
         for (int v = 0; v < 2; v++) begin
            comparator_raw <= 1'b0;
            wr(cmpc_pkg::ADDR_CONTROL, {24'h000000, 2'b01, v[0], 2'b00, s[1:0], 1'b0});
            wr(cmpc_pkg::ADDR_ENABLE, {31'h00000000, v[0]});
            settle(6);
            wr(cmpc_pkg::ADDR_CLEAR, 32'h00000003);
            for (int k = 0; k < 2; k++) begin
               comparator_raw <= ~comparator_raw;
               settle(6);
               `CHK("irq", hit(s[1:0], comparator_raw ^ v[0] ^ 1'b1, comparator_raw ^ v[0]) & v[0], irq)
               rd(cmpc_pkg::ADDR_STATUS, d);
               `CHK("flag", {31'h00000000, hit(s[1:0], ~comparator_raw ^ v[0], comparator_raw ^ v[0])}, d)
               wr(cmpc_pkg::ADDR_CLEAR, 32'h00000003);
            end
         end
      end
      // A polarity flip with a steady input still changes the result bit.
      wr(cmpc_pkg::ADDR_CONTROL, 32'h00000044);
      settle(6);
      rd(cmpc_pkg::ADDR_STATUS, d);
      `CHK("flip", 32'h00000001, d)
      // Power off: input changes are ignored.
      wr(cmpc_pkg::ADDR_CONTROL, 32'h00000004);
      wr(cmpc_pkg::ADDR_CLEAR, 32'h00000003);
      comparator_raw <= ~comparator_raw;
      settle(6);
      rd(cmpc_pkg::ADDR_STATUS, d);
      `CHK("off", 32'h00000000, d)
      // Asleep with a clear flag, an input change wakes the core.
      wr(cmpc_pkg::ADDR_CONTROL, 32'h00000044);
      core_sleeping <= 1'b1;
      settle(6);
      wr(cmpc_pkg::ADDR_CLEAR, 32'h00000003);
      comparator_raw <= ~comparator_raw;
      settle(6);
      `CHK("wake", 1'b1, wake_request)
      rd(cmpc_pkg::ADDR_STATUS, d);
      `CHK("wake_st", 32'h00000003, d)
      rd(cmpc_pkg::ADDR_CONTROL, d);
      `CHK("sleep_ctl", {24'h000000, 3'h2, comparator_raw, 4'h4}, d)
      // An edge flag left set from the last event blocks the wake request.
      wr(cmpc_pkg::ADDR_CLEAR, 32'h00000002);
      comparator_raw <= ~comparator_raw;
      settle(6);
      `CHK("no_wake", 1'b0, wake_request)
      core_sleeping <= 1'b0;
      // Port reads while the comparator owns the pins.
      wr(cmpc_pkg::ADDR_CONTROL, 32'h00000081);
      for (int i = 0; i < 6; i++) begin
         h = $random(seed);
         c = $random(seed);
         wr(cmpc_pkg::ADDR_PORT, {22'h000000, c[1:0], 6'h00, h});
         rd(cmpc_pkg::ADDR_PORT, d);
         `CHK("port", c[1:0] & ~h, d[1:0])
      end
      // Unmapped places read zero and swallow writes.
      wr(12'h020, 32'hFFFFFFFF);
      rd(12'h020, d);
      `CHK("unmapped", 32'h00000000, d)
      rd(cmpc_pkg::ADDR_CONTROL, d);
      `CHK("ctrl_kept", {24'h000000, 3'h4, comparator_raw, 4'h1}, d)
      wrap_up();
   end
endmodule
`default_nettype wire
